//--- hdl/plhip_pkg.sv
// Purpose: shared constants for the powerline host port link
// Assumes: one system clock at 25 MHz, i2c speeds well below it
// Notes: open-drain lines carry in, out and output enable (enable low = drive low)
package plhip_pkg;
    localparam int PLHIP_ADDR_W = 7;
    localparam logic [6:0] PLHIP_TARGET_ADDR = 7'h01;
    localparam int PLHIP_ARRAY_DEPTH = 256;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam int CLK_HZ = 25000000;
    localparam int SCL_HZ = 100000;
    localparam int QTR_CYCLES = CLK_HZ / (SCL_HZ * 4);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [7:0] SEND_OFFSET = 8'h06;
    localparam logic [7:0] SEND_ONE_BYTE = 8'h81;
    localparam logic [7:0] STATUS_OFFSET = 8'h69;
    localparam int IND_BAND = 1;
    localparam int IND_RX = 3;
    localparam int IND_TX = 5;
endpackage : plhip_pkg

//--- hdl/plhip_bus_if.sv
// Purpose: two-wire bus between host and device ends
// Assumes: wired-and resolution with pull-up when nobody drives low
// Notes: enables are active low; a low enable pulls the line to 0
interface plhip_bus_if;
    logic scl_oe_n_host;
    logic sda_oe_n_host;
    logic scl_oe_n_dev;
    logic sda_oe_n_dev;
    logic scl;
    logic sda;
    // wired-and of both ends
    assign scl = scl_oe_n_host & scl_oe_n_dev;
    assign sda = sda_oe_n_host & sda_oe_n_dev;
    modport host (output scl_oe_n_host, output sda_oe_n_host, input scl, input sda);
    modport device (output scl_oe_n_dev, output sda_oe_n_dev, input scl, input sda);
endinterface : plhip_bus_if

//--- hdl/plhip_device.sv
// Purpose: i2c target port onto the transceiver parameter array, plus indicators
// Assumes: scl and sda are asynchronous and pass a three-stage synchroniser
// Notes: the array lives here; the transceiver side reads and writes it by port
import plhip_pkg::*;

// Overview of operation
// - write starts with address, direction bit zero
// - host sends address, offset, optional data
// - offset-only write sets read pointer
// - read: host sends address only, clocks data
// - read returns array data from latched offset
// - address fixed at build; rest via array
// - indicators follow their status active/complete
// - band indicator follows line occupied status
// - transmit indicator on while sending message
// - receive indicator on while receiving packet
// - indicators active high on port bits 1,3,5
// - stretch clock low while packet transmitting; here only outside S_IDLE, from the next scl fall
// - host sends message: write 81 to 06
// - host polls status at offset 69
module plhip_device (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // two-wire bus
    plhip_bus_if.device bus,
    // transceiver status
    input wire logic band_occupied,
    input wire logic rx_active,
    input wire logic tx_active,
    // transceiver access to the parameter array
    input wire logic [7:0] xcvr_addr,
    input wire logic xcvr_wr,
    input wire logic [7:0] xcvr_wdata,
    output logic [7:0] xcvr_rdata,
    output logic host_wr_pulse,
    output logic [7:0] host_wr_addr,
    // indicator port, bits 1, 3 and 5 used
    output logic [7:0] indicator_port
);
    import plhip_pkg::*;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ADDR = 6'b000010,
        S_WBYTE = 6'b000100,
        S_RBYTE = 6'b001000,
        S_ACK = 6'b010000,
        S_RACK = 6'b100000
    } plhip_dst_type;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        plhip_dst_type st;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic first_w;
        logic rd;
        logic [7:0] ptr;
        logic sda_oe_n;
        logic scl_oe_n;
        logic wr_pulse;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] ind;
        logic [7:0] xrd;
    } plhip_dev_type;

    plhip_dev_type st_q, st_d;
    logic [7:0] mem [0:PLHIP_ARRAY_DEPTH-1];
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] rd_byte;

    assign rd_byte = mem[st_q.ptr];
    // a change counts once stages two and three agree; stage one read only by stage two
    always_comb begin
        st_d = st_q;
        st_d.wr_pulse = 1'b0;
        st_d.scl_s = {st_q.scl_s[1:0], bus.scl};
        st_d.sda_s = {st_q.sda_s[1:0], bus.sda};
        if (st_q.scl_s[2] == st_q.scl_s[1]) begin
            st_d.scl_f = st_q.scl_s[2];
        end
        if (st_q.sda_s[2] == st_q.sda_s[1]) begin
            st_d.sda_f = st_q.sda_s[2];
        end
        scl_rise = !st_q.scl_f && st_d.scl_f;
        scl_fall = st_q.scl_f && !st_d.scl_f;
        start_c = st_q.scl_f && st_d.scl_f && st_q.sda_f && !st_d.sda_f;
        stop_c = st_q.scl_f && st_d.scl_f && !st_q.sda_f && st_d.sda_f;
        // indicators mirror status directly, active high
        st_d.ind = 8'h00;
        st_d.ind[IND_BAND] = band_occupied;
        st_d.ind[IND_RX] = rx_active;
        st_d.ind[IND_TX] = tx_active;
        st_d.xrd = mem[xcvr_addr];
        // hold scl low through a transmit; grab it only on a seen fall, never just after a release
        if (st_q.st != S_IDLE && tx_active && (scl_fall || !st_q.scl_oe_n)) begin
            st_d.scl_oe_n = 1'b0;
        end else if (!tx_active) begin
            st_d.scl_oe_n = 1'b1;
        end
        if (stop_c) begin
            st_d.st = S_IDLE;
            st_d.sda_oe_n = 1'b1;
        end else if (start_c) begin
            st_d.st = S_ADDR;
            st_d.bitn = 4'h0;
            st_d.sda_oe_n = 1'b1;
        end else if (st_q.scl_oe_n) begin
            case (st_q.st)
                S_IDLE: begin
                    st_d.sda_oe_n = 1'b1;
                end
                S_ADDR, S_WBYTE: begin
                    if (scl_rise) begin
                        st_d.shreg = {st_q.shreg[6:0], st_q.sda_f};
                        st_d.bitn = st_q.bitn + 4'h1;
                    end
                    if (scl_fall && st_q.bitn == BIT_LAST) begin
                        st_d.bitn = 4'h0;
                        if (st_q.st == S_ADDR) begin
                            if (st_q.shreg[7:1] == PLHIP_TARGET_ADDR) begin
                                st_d.rd = st_q.shreg[0];
                                st_d.first_w = 1'b1;
                                st_d.sda_oe_n = 1'b0;
                                st_d.st = S_ACK;
                            end else begin
                                st_d.st = S_IDLE;
                            end
                        end else begin
                            st_d.sda_oe_n = 1'b0;
                            st_d.st = S_ACK;
                            if (st_q.first_w) begin
                                st_d.ptr = st_q.shreg;
                                st_d.first_w = 1'b0;
                            end else begin
                                st_d.wr_pulse = 1'b1;
                                st_d.wr_addr = st_q.ptr;
                                st_d.wr_data = st_q.shreg;
                                st_d.ptr = st_q.ptr + 8'h01;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        if (st_q.rd) begin
                            st_d.shreg = rd_byte;
                            st_d.sda_oe_n = rd_byte[7];
                            st_d.bitn = 4'h1;
                            st_d.ptr = st_q.ptr + 8'h01;
                            st_d.st = S_RBYTE;
                        end else begin
                            st_d.sda_oe_n = 1'b1;
                            st_d.st = S_WBYTE;
                        end
                    end
                end
                S_RBYTE: begin
                    if (scl_fall) begin
                        if (st_q.bitn == BIT_LAST) begin
                            st_d.sda_oe_n = 1'b1;
                            st_d.st = S_RACK;
                        end else begin
                            st_d.sda_oe_n = st_q.shreg[3'(7 - st_q.bitn)];
                            st_d.bitn = st_q.bitn + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    // host nack ends the read; ack asks for the next byte
                    if (scl_rise) begin
                        st_d.st = st_q.sda_f ? S_IDLE : S_ACK;
                    end
                end
                default: begin
                    st_d.st = S_IDLE;
                end
            endcase
        end
    end

    // array: host writes win over transceiver writes to the same cycle
    always_ff @(posedge clk_sys) begin
        if (st_q.wr_pulse) begin
            mem[st_q.wr_addr] <= st_q.wr_data;
        end else if (xcvr_wr) begin
            mem[xcvr_addr] <= xcvr_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: S_IDLE,
                      bitn: 4'h0, shreg: 8'h00, first_w: 1'b0, rd: 1'b0, ptr: 8'h00,
                      sda_oe_n: 1'b1, scl_oe_n: 1'b1, wr_pulse: 1'b0, wr_addr: 8'h00,
                      wr_data: 8'h00, ind: 8'h00, xrd: 8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.scl_oe_n_dev = st_q.scl_oe_n;
    assign bus.sda_oe_n_dev = st_q.sda_oe_n;
    assign xcvr_rdata = st_q.xrd;
    assign host_wr_pulse = st_q.wr_pulse;
    assign host_wr_addr = st_q.wr_addr;
    assign indicator_port = st_q.ind;
endmodule : plhip_device

//--- hdl/plhip_host.sv
// Purpose: i2c master end that writes and reads the device parameter array
// Assumes: user request held until done; scl made here from clk_sys by a divider
// Notes: honours clock stretching by waiting for scl to read high
import plhip_pkg::*;

module plhip_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // two-wire bus
    plhip_bus_if.host bus,
    // user request: offset always sent; then one req_wdata byte on writes or one read byte on reads
    input wire logic req,
    input wire logic req_read,
    input wire logic [7:0] req_offset,
    input wire logic [7:0] req_wdata,
    output logic wdata_taken,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic nack_seen,
    output logic busy
);
    import plhip_pkg::*;

    typedef enum logic [6:0] {
        H_IDLE = 7'b0000001,
        H_START = 7'b0000010,
        H_BIT = 7'b0000100,
        H_STOP = 7'b0001000,
        H_RSTART = 7'b0010000,
        H_DONE = 7'b0100000,
        H_PAD = 7'b1000000
    } plhip_hst_type;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        plhip_hst_type st;
        logic [7:0] div;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [1:0] nbyte;
        logic rdphase;
        logic scl_oe_n;
        logic sda_oe_n;
        logic taken;
        logic [7:0] rdata;
        logic rvalid;
        logic nack;
        logic busy;
    } plhip_host_type;

    plhip_host_type h_q, h_d;
    logic tick;

    always_comb begin
        h_d = h_q;
        h_d.taken = 1'b0;
        h_d.rvalid = 1'b0;
        h_d.scl_s = {h_q.scl_s[1:0], bus.scl};
        h_d.sda_s = {h_q.sda_s[1:0], bus.sda};
        if (h_q.scl_s[2] == h_q.scl_s[1]) begin
            h_d.scl_f = h_q.scl_s[2];
        end
        if (h_q.sda_s[2] == h_q.sda_s[1]) begin
            h_d.sda_f = h_q.sda_s[2];
        end
        // quarter-bit enable; frozen while a released scl is still held low
        tick = (h_q.div == QTR_LAST);
        if (h_q.scl_oe_n && !h_q.scl_f && h_q.ph == 2'h2) begin
            h_d.div = 8'h00;
            tick = 1'b0;
        end else begin
            h_d.div = tick ? 8'h00 : h_q.div + 8'h01;
        end
        case (h_q.st)
            H_IDLE: begin
                h_d.busy = req;
                if (req) begin
                    // write phase: address with write bit, then offset
                    h_d.sh = {PLHIP_TARGET_ADDR, RW_WRITE};
                    h_d.nbyte = 2'h0;
                    h_d.rdphase = 1'b0;
                    h_d.nack = 1'b0;
                    h_d.st = H_START;
                    h_d.ph = 2'h0;
                end
            end
            H_START, H_RSTART: begin
                if (tick) begin
                    h_d.ph = h_q.ph + 2'h1;
                    if (h_q.ph == 2'h0) begin
                        h_d.sda_oe_n = 1'b1;
                        h_d.scl_oe_n = 1'b1;
                    end else if (h_q.ph == 2'h1) begin
                        h_d.sda_oe_n = 1'b0;
                    end else if (h_q.ph == 2'h2) begin
                        h_d.scl_oe_n = 1'b0;
                        h_d.st = H_BIT;
                        h_d.bitn = 4'h0;
                        h_d.ph = 2'h0;
                    end
                end
            end
            H_BIT: begin
                if (tick) begin
                    h_d.ph = h_q.ph + 2'h1;
                    if (h_q.ph == 2'h0) begin
                        // data bits, then release for the ack slot; on reads we nack every byte
                        if (h_q.bitn == BIT_LAST) begin
                            h_d.sda_oe_n = !(h_q.rdphase && h_q.nbyte != 2'h0) ? 1'b1 : 1'b1;
                        end else if (h_q.rdphase && h_q.nbyte != 2'h0) begin
                            h_d.sda_oe_n = 1'b1;
                        end else begin
                            h_d.sda_oe_n = h_q.sh[7];
                        end
                    end else if (h_q.ph == 2'h1) begin
                        h_d.scl_oe_n = 1'b1;
                    end else if (h_q.ph == 2'h2) begin
                        if (h_q.bitn != BIT_LAST) begin
                            h_d.sh = {h_q.sh[6:0], h_q.sda_f};
                        end else if (h_q.sda_f && !(h_q.rdphase && h_q.nbyte != 2'h0)) begin
                            h_d.nack = 1'b1; // target ignored us
                        end
                    end else begin
                        h_d.scl_oe_n = 1'b0;
                        h_d.bitn = h_q.bitn + 4'h1;
                        if (h_q.bitn == BIT_LAST) begin
                            h_d.bitn = 4'h0;
                            h_d.nbyte = h_q.nbyte + 2'h1;
                            if (h_q.nack) begin
                                h_d.st = H_STOP;
                            end else if (h_q.rdphase) begin
                                // one byte clocked in, nacked, then stop
                                if (h_q.nbyte != 2'h0) begin
                                    h_d.rdata = h_q.sh;
                                    h_d.rvalid = 1'b1;
                                    h_d.nbyte = 2'h3; // not 2, so the stop ends the request instead of re-reading
                                    h_d.st = H_STOP;
                                end
                            end else if (h_q.nbyte == 2'h0) begin
                                h_d.sh = req_offset;
                            end else if (h_q.nbyte == 2'h1 && !req_read) begin
                                h_d.sh = req_wdata;
                                h_d.taken = 1'b1;
                            end else begin
                                h_d.st = req_read ? H_PAD : H_STOP;
                            end
                        end
                    end
                end
            end
            H_PAD: begin
                // stop after offset-only write, then start a read with address only
                h_d.st = H_STOP;
                h_d.rdphase = 1'b1;
            end
            H_STOP: begin
                if (tick) begin
                    h_d.ph = h_q.ph + 2'h1;
                    if (h_q.ph == 2'h0) begin
                        h_d.sda_oe_n = 1'b0;
                    end else if (h_q.ph == 2'h1) begin
                        h_d.scl_oe_n = 1'b1;
                    end else if (h_q.ph == 2'h2) begin
                        h_d.sda_oe_n = 1'b1;
                    end else begin
                        h_d.ph = 2'h0;
                        if (h_q.rdphase && h_q.nbyte == 2'h2 && !h_q.nack) begin
                            h_d.sh = {PLHIP_TARGET_ADDR, RW_READ};
                            h_d.nbyte = 2'h0;
                            h_d.st = H_RSTART;
                        end else begin
                            h_d.st = H_DONE;
                        end
                    end
                end
            end
            H_DONE: begin
                h_d.busy = 1'b0;
                if (!req) begin
                    h_d.st = H_IDLE;
                end
            end
            default: begin
                h_d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            h_q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: H_IDLE,
                     div: 8'h00, ph: 2'h0, bitn: 4'h0, sh: 8'h00, nbyte: 2'h0,
                     rdphase: 1'b0, scl_oe_n: 1'b1, sda_oe_n: 1'b1, taken: 1'b0,
                     rdata: 8'h00, rvalid: 1'b0, nack: 1'b0, busy: 1'b0};
        end else begin
            h_q <= h_d;
        end
    end

    assign bus.scl_oe_n_host = h_q.scl_oe_n;
    assign bus.sda_oe_n_host = h_q.sda_oe_n;
    assign wdata_taken = h_q.taken;
    assign rdata = h_q.rdata;
    assign rdata_valid = h_q.rvalid;
    assign nack_seen = h_q.nack;
    assign busy = h_q.busy;
endmodule : plhip_host

//--- dv/plhip_link_properties.sv
// Purpose: wire and indicator properties for the host port link
// Assumes: one clock domain, synchronous active-high reset
// Notes: sits beside the first bus in tb_top, no bind
module plhip_link_properties
    import plhip_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus enables and resolved lines
    input wire logic scl_oe_n_host,
    input wire logic sda_oe_n_host,
    input wire logic scl_oe_n_dev,
    input wire logic sda_oe_n_dev,
    input wire logic scl,
    input wire logic sda,
    // transceiver status and indicators
    input wire logic band_occupied,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic [7:0] indicator_port
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // every end lets go of both lines on the first edge out of reset
    property p_rel;
        $fell(rst) |-> scl_oe_n_host && sda_oe_n_host && scl_oe_n_dev && sda_oe_n_dev;
    endproperty
    a_rel: assert property (p_rel) else $error("line held after reset");
    // device data may only move while the clock is low, else it fakes a start or stop
    property p_sda_low;
        $changed(sda_oe_n_dev) |-> !scl;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("device sda moved with scl high");
    // a driven low bit stands for at least eight clk_sys cycles
    property p_ack_stand;
        $fell(sda_oe_n_dev) |-> !sda_oe_n_dev [*8];
    endproperty
    a_ack_stand: assert property (p_ack_stand) else $error("device bit dropped early");
    // the device only grabs the clock when a packet is going out
    property p_str_cause;
        $fell(scl_oe_n_dev) |-> $past(tx_active) || $past(tx_active, 2);
    endproperty
    a_str_cause: assert property (p_str_cause) else $error("scl stretched without tx");
    property p_str_hold;
        tx_active && !scl_oe_n_dev |=> !scl_oe_n_dev;
    endproperty
    a_str_hold: assert property (p_str_hold) else $error("stretch ended during tx");
    property p_str_end;
        !tx_active [*4] |-> scl_oe_n_dev;
    endproperty
    a_str_end: assert property (p_str_end) else $error("stretch outlived tx");
    // indicators follow their status one cycle later, spare bits stay low
    property p_ind_band;
        !$past(rst) |-> indicator_port[IND_BAND] == $past(band_occupied);
    endproperty
    a_ind_band: assert property (p_ind_band) else $error("band indicator wrong");
    property p_ind_rx;
        !$past(rst) |-> indicator_port[IND_RX] == $past(rx_active);
    endproperty
    a_ind_rx: assert property (p_ind_rx) else $error("receive indicator wrong");
    property p_ind_tx;
        !$past(rst) |-> indicator_port[IND_TX] == $past(tx_active);
    endproperty
    a_ind_tx: assert property (p_ind_tx) else $error("transmit indicator wrong");
    property p_ind_spare;
        (indicator_port & 8'hd5) == 8'h00;
    endproperty
    a_ind_spare: assert property (p_ind_spare) else $error("spare indicator bit set");
endmodule : plhip_link_properties

//--- dv/tb_top.sv
// Purpose: self-checking bench with host and device joined on one bus
// Assumes: 25 MHz clk_sys, inputs change 1 ns after the rising edge
// Notes: a second bus joins a second device to a bench bit-banger
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import plhip_pkg::*;
    logic clk_sys = 1'h0, rst = 1'h1;
    logic req = 1'h0, req_read = 1'h0, rdata_valid, nack_seen, busy, host_wr_pulse, wdata_taken;
    logic [7:0] req_offset = 8'h00, req_wdata = 8'h00, rdata, host_wr_addr, indicator_port;
    logic band_occupied = 1'h0, rx_active = 1'h0, tx_active = 1'h0, x1_wr = 1'h0;
    logic [7:0] x1_addr = 8'h00, x1_wdata = 8'h00, x1_rdata, x2_addr = 8'h00, x2_rdata;
    logic h2_scl = 1'h1, h2_sda = 1'h1, ack;
    int bad_count = 0, checks = 0, nb = 100;
    logic [7:0] sh, wr_seen, got;
    logic [7:0] fq[$];
    logic [7:0] fexp[6] = '{8'h02, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02};
    plhip_bus_if b1();
    plhip_bus_if b2();
    // the bench plays host on the second bus
    assign b2.scl_oe_n_host = h2_scl;
    assign b2.sda_oe_n_host = h2_sda;
    plhip_host i_plhip_host (.clk_sys(clk_sys), .rst(rst), .bus(b1), .req(req), .req_read(req_read),
        .req_offset(req_offset), .req_wdata(req_wdata), .wdata_taken(wdata_taken), .rdata(rdata),
        .rdata_valid(rdata_valid), .nack_seen(nack_seen), .busy(busy));
    plhip_device i_plhip_device (.clk_sys(clk_sys), .rst(rst), .bus(b1), .band_occupied(band_occupied),
        .rx_active(rx_active), .tx_active(tx_active), .xcvr_addr(x1_addr), .xcvr_wr(x1_wr),
        .xcvr_wdata(x1_wdata), .xcvr_rdata(x1_rdata), .host_wr_pulse(host_wr_pulse),
        .host_wr_addr(host_wr_addr), .indicator_port(indicator_port));
    plhip_device i_plhip_device_2 (.clk_sys(clk_sys), .rst(rst), .bus(b2), .band_occupied(1'h0),
        .rx_active(1'h0), .tx_active(1'h0), .xcvr_addr(x2_addr), .xcvr_wr(1'h0), .xcvr_wdata(8'h00),
        .xcvr_rdata(x2_rdata), .host_wr_pulse(), .host_wr_addr(), .indicator_port());
    plhip_link_properties i_plhip_link_properties (.clk_sys(clk_sys), .rst(rst),
        .scl_oe_n_host(b1.scl_oe_n_host), .sda_oe_n_host(b1.sda_oe_n_host), .scl_oe_n_dev(b1.scl_oe_n_dev),
        .sda_oe_n_dev(b1.sda_oe_n_dev), .scl(b1.scl), .sda(b1.sda), .band_occupied(band_occupied),
        .rx_active(rx_active), .tx_active(tx_active), .indicator_port(indicator_port));
    // clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // wire monitor: first byte after each start, msb first
    always @(negedge b1.sda) begin
        if (b1.scl === 1'h1) nb = 0;
    end
    always @(posedge b1.scl) begin
        sh = {sh[6:0], b1.sda};
        if (nb == 7) fq.push_back(sh);
        nb++;
    end
    // array offset of the last byte the host wrote
    always @(posedge clk_sys) begin
        if (host_wr_pulse === 1'h1) wr_seen <= host_wr_addr;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // one user request, held until busy drops; bounded so a hang shows up
    task automatic hreq(input logic rd, input logic [7:0] off, input logic [7:0] wd, output logic [7:0] d);
        int n, n_tk;
        n = 0;
        n_tk = 0;
        d = 8'h00;
        {req_read, req_offset, req_wdata, req} = {rd, off, wd, 1'h1};
        do begin
            tick(1);
            n++;
            if (rdata_valid === 1'h1) d = rdata;
            if (wdata_taken === 1'h1) n_tk++;
        end while ((busy !== 1'h0 || n < 3) && n < 30000);
        chk({7'h00, busy}, 8'h00);
        chk(8'(n_tk), {7'h00, !rd});
        req = 1'h0;
        tick(1);
        chk({7'h00, nack_seen}, 8'h00);
    endtask : hreq
    // bit-banger: quarter of 8 cycles keeps well clear of the 3-stage synchroniser
    task automatic bbit(input logic v, output logic s);
        h2_sda = v;
        tick(8);
        h2_scl = 1'h1;
        tick(8);
        s = b2.sda;
        tick(8);
        h2_scl = 1'h0;
        tick(8);
    endtask : bbit
    // byte out msb first, then ninth bit m; d holds what the line showed
    task automatic bx(input logic [7:0] b, input logic m, output logic [7:0] d, output logic s);
        for (int i = 7; i >= 0; i--) bbit(b[i], d[i]);
        bbit(m, s);
    endtask : bx
    task automatic bcond(input logic stop);
        // set sda before raising scl (scl is low before a stop, already high before a start), so raising scl cannot fake a condition
        h2_sda = stop ? 1'h0 : 1'h1;
        tick(8);
        h2_scl = 1'h1;
        tick(8);
        h2_sda = stop;
        tick(8);
        h2_scl = stop;
        tick(8);
    endtask : bcond
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // watchdog, about twice the expected run
    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
    // main sequence
    initial begin
        tick(20);
        rst = 1'h0;
        tick(1);
        chk({6'h00, b1.scl, b1.sda}, 8'h03);
        $display("test idle done");
        for (int p = 0; p < 8; p++) begin
            {band_occupied, rx_active, tx_active} = 3'(p);
            tick(2);
            chk(indicator_port, {2'h0, tx_active, 1'h0, rx_active, 1'h0, band_occupied, 1'h0});
        end
        {band_occupied, rx_active, tx_active} = 3'h0;
        $display("test indicators done");
        hreq(1'h0, SEND_OFFSET, SEND_ONE_BYTE, got);
        chk(wr_seen, 8'h06);
        x1_addr = 8'h06;
        tick(2);
        chk(x1_rdata, 8'h81);
        hreq(1'h1, 8'h06, 8'h00, got);
        chk(got, 8'h81);
        xw_status: begin
            {x1_addr, x1_wdata, x1_wr} = {8'h69, 8'h5a, 1'h1};
            tick(1);
            x1_wr = 1'h0;
        end
        hreq(1'h1, STATUS_OFFSET, 8'h00, got);
        chk(got, 8'h5a);
        $display("test host write read done");
        fork
            hreq(1'h0, 8'h20, 8'h77, got);
            begin
                tick(1500);
                tx_active = 1'h1;
                tick(1000);
                chk({7'h00, b1.scl}, 8'h00);
                chk(indicator_port, 8'h20);
                tick(500);
                tx_active = 1'h0;
            end
        join
        x1_addr = 8'h20;
        tick(2);
        chk(x1_rdata, 8'h77);
        chk(8'(fq.size()), 8'h06);
        foreach (fexp[i]) if (i < fq.size()) chk(fq[i], fexp[i]);
        $display("test stretch and wire done");
        bcond(1'h0);
        bx(8'h0a, 1'h1, got, ack);
        bcond(1'h1);
        chk({7'h00, ack}, 8'h01);
        bcond(1'h0);
        bx(8'h02, 1'h1, got, ack);
        chk({7'h00, ack}, 8'h00);
        bx(8'h10, 1'h1, got, ack);
        bx(8'ha5, 1'h1, got, ack);
        bx(8'h3c, 1'h1, got, ack);
        bcond(1'h1);
        x2_addr = 8'h11;
        tick(2);
        chk(x2_rdata, 8'h3c);
        bcond(1'h0);
        bx(8'h02, 1'h1, got, ack);
        bx(8'h10, 1'h1, got, ack);
        bcond(1'h1);
        bcond(1'h0);
        bx(8'h03, 1'h1, got, ack);
        chk({7'h00, ack}, 8'h00);
        bx(8'hff, 1'h0, got, ack);
        chk(got, 8'ha5);
        bx(8'hff, 1'h1, got, ack);
        chk(got, 8'h3c);
        bcond(1'h1);
        $display("test bit-banged target done");
        end_sim();
    end
endmodule : tb_top
